//--- hw/mrb_pkg.sv
// package: constants and types of the serial responder bridge
package mrb_pkg;
  // system clock and serial timing
  localparam int CLK_HZ_DEFAULT = 20_000_000;
  localparam int BAUD_19200 = 19200;
  localparam int BAUD_9600 = 9600;
  localparam int BAUD_4800 = 4800;
  localparam int BAUD_2400 = 2400;
  localparam int BAUD_1200 = 1200;
  localparam int BAUD_600 = 600;
  localparam int BAUD_300 = 300;
  localparam logic [5:0] GAP_BITS = 6'h27; // 3.5 characters of 11 bits, rounded up
  localparam int CYC_W = 17;

  // rate selector codes
  localparam logic [2:0] RATE_19200 = 3'h7;
  localparam logic [2:0] RATE_9600 = 3'h6;
  localparam logic [2:0] RATE_4800 = 3'h5;
  localparam logic [2:0] RATE_2400 = 3'h4;
  localparam logic [2:0] RATE_1200 = 3'h3;
  localparam logic [2:0] RATE_600 = 3'h2;
  localparam logic [2:0] RATE_300 = 3'h1;
  localparam logic [2:0] RATE_RESERVED = 3'h0;

  // register byte offsets
  localparam logic [8:0] OFS_CTRL = 9'h000;
  localparam logic [8:0] OFS_STATUS = 9'h004;
  localparam logic [8:0] OFS_TX_LEN = 9'h008;
  localparam logic [8:0] OFS_DROPS = 9'h00C;
  localparam logic [8:0] OFS_BUF = 9'h100;

  // control and status register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_RATE_LSB = 1;
  localparam int CTRL_PAR_EN = 4;
  localparam int CTRL_PAR_EVEN = 5;
  localparam int CTRL_STN_LSB = 6;
  localparam int STAT_PENDING = 0;
  localparam int STAT_TX = 1;
  localparam int STAT_LEN_LSB = 8;

  // reset values
  localparam logic RST_EN = 1'b1;
  localparam logic [2:0] RST_RATE = RATE_9600;
  localparam logic [4:0] RST_STATION = 5'h01;

  // frame layout and function codes
  localparam int BUF_DEPTH = 64;
  localparam logic [6:0] MIN_FRAME = 7'h04;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [7:0] FC_READ_COILS = 8'h01;
  localparam logic [7:0] FC_READ_INPUTS = 8'h02;
  localparam logic [7:0] FC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FC_READ_INPUT_REG = 8'h04;
  localparam logic [7:0] FC_WRITE_COIL = 8'h05;
  localparam logic [7:0] FC_WRITE_REG = 8'h06;
  localparam logic [7:0] FC_WRITE_COILS = 8'h0F;
  localparam logic [7:0] FC_WRITE_REGS = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILLEGAL_FC = 8'h01;
  localparam logic [6:0] EXC_LEN = 7'h03;

  typedef enum logic [2:0] {
    MRB_IDLE = 3'h0,
    MRB_CHECK = 3'h1,
    MRB_WAIT_HOST = 3'h3,
    MRB_TX_DATA = 3'h2,
    MRB_TX_CRC_LO = 3'h6,
    MRB_TX_CRC_HI = 3'h7
  } mrb_state_t;
endpackage

//--- hw/mrb_char_if.sv
// interface: character link between frame logic and serial engine
interface mrb_char_if;
  logic [mrb_pkg::CYC_W-1:0] bit_cycles;
  logic parity_enable;
  logic parity_even_select;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_err;
  logic rx_gap;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_ready;
  logic tx_active;

  modport ctrl (
    output bit_cycles, parity_enable, parity_even_select, tx_valid, tx_data,
    input rx_valid, rx_data, rx_err, rx_gap, tx_ready, tx_active
  );
  modport phy (
    input bit_cycles, parity_enable, parity_even_select, tx_valid, tx_data,
    output rx_valid, rx_data, rx_err, rx_gap, tx_ready, tx_active
  );
endinterface

//--- hw/mrb_char_engine.sv
// module: half-duplex character engine with parity and silence detection
module mrb_char_engine (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic line_rx,
  output logic line_tx,
  output logic line_tx_oe,
  mrb_char_if.phy ch
);
  typedef struct packed {
    logic [2:0] sync;
    logic rx_line;
    logic rx_busy;
    logic [3:0] rx_bit;
    logic [mrb_pkg::CYC_W-1:0] rx_cnt;
    logic [7:0] rx_sh;
    logic rx_perr;
    logic rx_valid;
    logic rx_err;
    logic gap_armed;
    logic [mrb_pkg::CYC_W-1:0] gap_cnt;
    logic [5:0] gap_bits;
    logic rx_gap;
    logic tx_busy;
    logic [3:0] tx_bit;
    logic [mrb_pkg::CYC_W-1:0] tx_cnt;
    logic [10:0] tx_sh;
    logic tx_out;
  } mrb_eng_t;

  mrb_eng_t r;
  mrb_eng_t next_r;
  logic [3:0] rx_stop_bit;
  logic [3:0] tx_last_bit;
  logic par_bit;

  assign ch.rx_valid = r.rx_valid;
  assign ch.rx_data = r.rx_sh;
  assign ch.rx_err = r.rx_err;
  assign ch.rx_gap = r.rx_gap;
  // a character being received holds off the transmitter
  assign ch.tx_ready = ~r.tx_busy & ~r.rx_busy;
  assign ch.tx_active = r.tx_busy;
  assign line_tx = r.tx_out;
  assign line_tx_oe = r.tx_busy;

  // start, 8 data, optional parity, 1 stop
  assign rx_stop_bit = ch.parity_enable ? 4'hA : 4'h9;
  assign tx_last_bit = ch.parity_enable ? 4'hA : 4'h9;
  // even: parity bit equals xor of data; odd: its inverse
  assign par_bit = (^ch.tx_data) ^ ~ch.parity_even_select;

  // receive, silence timer and transmit
  always_comb begin
    next_r = r;
    next_r.rx_valid = 1'b0;
    next_r.rx_gap = 1'b0;
    next_r.sync = {r.sync[1:0], line_rx};
    // the line level moves only when the two later stages agree
    if (r.sync[1] == r.sync[2]) begin
      next_r.rx_line = r.sync[2];
    end
    if (!r.rx_busy) begin
      // half duplex: our own transmission is never received
      if (!r.tx_busy && !r.rx_line) begin
        next_r.rx_busy = 1'b1;
        next_r.rx_bit = 4'h0;
        next_r.rx_cnt = ch.bit_cycles >> 1;
        next_r.rx_perr = 1'b0;
      end
    end else if (r.rx_cnt != '0) begin
      next_r.rx_cnt = r.rx_cnt - 1'b1;
    end else begin
      next_r.rx_cnt = ch.bit_cycles - 1'b1;
      next_r.rx_bit = r.rx_bit + 1'b1;
      if (r.rx_bit == 4'h0) begin
        next_r.rx_busy = ~r.rx_line; // glitch rather than a start bit
      end else if (r.rx_bit <= 4'h8) begin
        next_r.rx_sh = {r.rx_line, r.rx_sh[7:1]};
      end else if (r.rx_bit == rx_stop_bit) begin
        next_r.rx_busy = 1'b0;
        next_r.rx_valid = 1'b1;
        next_r.rx_err = r.rx_perr | ~r.rx_line; // framing counts as error too
        next_r.gap_armed = 1'b1;
        next_r.gap_cnt = '0;
        next_r.gap_bits = '0;
      end else begin
        next_r.rx_perr = (^r.rx_sh) ^ r.rx_line ^ ~ch.parity_even_select;
      end
    end
    // end of frame after 39 quiet bit times, 3.5 characters of 11 bits
    if (r.rx_busy || !r.rx_line) begin
      next_r.gap_cnt = '0;
      next_r.gap_bits = '0;
    end else if (r.gap_armed) begin
      if (r.gap_cnt >= ch.bit_cycles - 1'b1) begin
        next_r.gap_cnt = '0;
        next_r.gap_bits = r.gap_bits + 1'b1;
        if (r.gap_bits + 1'b1 == mrb_pkg::GAP_BITS) begin
          next_r.rx_gap = 1'b1;
          next_r.gap_armed = 1'b0;
        end
      end else begin
        next_r.gap_cnt = r.gap_cnt + 1'b1;
      end
    end
    // transmitter: shift out lsb first, line idles high
    if (!r.tx_busy) begin
      next_r.tx_out = 1'b1;
      if (ch.tx_valid && !r.rx_busy) begin
        next_r.tx_busy = 1'b1;
        next_r.tx_bit = 4'h0;
        next_r.tx_cnt = ch.bit_cycles - 1'b1;
        next_r.tx_out = 1'b0;
        next_r.tx_sh = ch.parity_enable ? {1'b1, par_bit, ch.tx_data, 1'b0}
                                        : {2'h3, ch.tx_data, 1'b0};
      end
    end else if (r.tx_cnt != '0) begin
      next_r.tx_cnt = r.tx_cnt - 1'b1;
    end else if (r.tx_bit == tx_last_bit) begin
      next_r.tx_busy = 1'b0;
      next_r.tx_out = 1'b1;
    end else begin
      next_r.tx_cnt = ch.bit_cycles - 1'b1;
      next_r.tx_bit = r.tx_bit + 1'b1;
      next_r.tx_sh = {1'b1, r.tx_sh[10:1]};
      next_r.tx_out = r.tx_sh[1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      r <= '0;
      r.sync <= 3'h7;
      r.rx_line <= 1'b1;
      r.tx_out <= 1'b1;
    end else begin
      r <= next_r;
    end
  end
endmodule

//--- hw/mrb_bridge.sv
// module: serial responder frame logic, command issue and register slave
module mrb_bridge #(
  parameter int CLK_HZ = mrb_pkg::CLK_HZ_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic line_rx,
  output logic line_tx,
  output logic line_tx_oe,
  output logic internal_read_command,
  output logic internal_write_command,
  output logic [7:0] cmd_function,
  output logic [15:0] cmd_start,
  output logic [15:0] cmd_quantity
);
  typedef struct packed {
    mrb_pkg::mrb_state_t state;
    logic enable;
    logic [2:0] rate_sel;
    logic parity_enable;
    logic parity_even_select;
    logic [4:0] station;
    logic [mrb_pkg::CYC_W-1:0] bit_cycles;
    logic [6:0] rx_len;
    logic [15:0] crc;
    logic bad;
    logic [6:0] tx_len;
    logic [6:0] tx_idx;
    logic tx_valid;
    logic [7:0] tx_data;
    logic [mrb_pkg::BUF_DEPTH-1:0][7:0] frame;
    logic [15:0] drops;
    logic rd_cmd;
    logic wr_cmd;
    logic [7:0] fc;
    logic [15:0] start;
    logic [15:0] qty;
    logic waitreq;
    logic [31:0] rdata;
  } mrb_top_t;

  mrb_top_t r;
  mrb_top_t next_r;
  logic [8:0] ofs;
  logic [5:0] buf_idx;
  logic acc;

  mrb_char_if ch ();

  mrb_char_engine u_engine (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .line_rx(line_rx),
    .line_tx(line_tx),
    .line_tx_oe(line_tx_oe),
    .ch(ch)
  );

  assign ch.bit_cycles = r.bit_cycles;
  assign ch.parity_enable = r.parity_enable;
  assign ch.parity_even_select = r.parity_even_select;
  assign ch.tx_valid = r.tx_valid;
  assign ch.tx_data = r.tx_data;

  assign avs_readdata = r.rdata;
  assign avs_waitrequest = r.waitreq; // held in its own flop, no gate on the pin
  assign internal_read_command = r.rd_cmd;
  assign internal_write_command = r.wr_cmd;
  assign cmd_function = r.fc;
  assign cmd_start = r.start;
  assign cmd_quantity = r.qty;

  assign ofs = {avs_address, 2'b00};
  assign buf_idx = avs_address[5:0];
  // the access completes at the edge where waitrequest is seen low
  assign acc = ~r.waitreq & (avs_read | avs_write);

  // cycles per bit for each selector code; reserved code yields zero
  function automatic logic [mrb_pkg::CYC_W-1:0] rate_cycles(input logic [2:0] sel);
    int baud;
    baud = 0;
    case (sel)
      mrb_pkg::RATE_19200: baud = mrb_pkg::BAUD_19200;
      mrb_pkg::RATE_9600: baud = mrb_pkg::BAUD_9600;
      mrb_pkg::RATE_4800: baud = mrb_pkg::BAUD_4800;
      mrb_pkg::RATE_2400: baud = mrb_pkg::BAUD_2400;
      mrb_pkg::RATE_1200: baud = mrb_pkg::BAUD_1200;
      mrb_pkg::RATE_600: baud = mrb_pkg::BAUD_600;
      mrb_pkg::RATE_300: baud = mrb_pkg::BAUD_300;
      default: baud = 0;
    endcase
    rate_cycles = (baud == 0) ? '0 : mrb_pkg::CYC_W'(CLK_HZ / baud);
  endfunction

  // one crc-16 byte step, reflected polynomial
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ mrb_pkg::CRC_POLY) : (x >> 1);
    end
    crc_step = x;
  endfunction

  // frame handling, command issue and register access
  always_comb begin
    next_r = r;
    next_r.rd_cmd = 1'b0;
    next_r.wr_cmd = 1'b0;
    next_r.waitreq = 1'b1;
    next_r.bit_cycles = rate_cycles(r.rate_sel);
    if (r.tx_valid && ch.tx_ready) begin
      next_r.tx_valid = 1'b0;
    end
    case (r.state)
      mrb_pkg::MRB_IDLE: begin
        if (ch.rx_valid) begin
          // every byte up to the buffer depth is collected, whoever it is addressed to
          if (r.rx_len < 7'(mrb_pkg::BUF_DEPTH)) begin
            next_r.frame[r.rx_len[5:0]] = ch.rx_data;
            next_r.rx_len = r.rx_len + 1'b1;
          end else begin
            next_r.bad = 1'b1; // overlong frame cannot be checked
          end
          next_r.crc = crc_step(r.crc, ch.rx_data);
          next_r.bad = next_r.bad | ch.rx_err;
        end else if (ch.rx_gap) begin
          next_r.state = mrb_pkg::MRB_CHECK;
        end
      end
      mrb_pkg::MRB_CHECK: begin
        next_r.state = mrb_pkg::MRB_IDLE;
        next_r.rx_len = '0;
        next_r.crc = mrb_pkg::CRC_INIT;
        next_r.bad = 1'b0;
        if (r.bad || r.crc != '0 || r.rx_len < mrb_pkg::MIN_FRAME) begin
          next_r.drops = r.drops + 1'b1;
        end else if (r.enable && r.frame[0] == {3'h0, r.station}) begin
          next_r.fc = r.frame[1];
          next_r.start = {r.frame[2], r.frame[3]};
          next_r.qty = {r.frame[4], r.frame[5]};
          case (r.frame[1])
            mrb_pkg::FC_READ_COILS, mrb_pkg::FC_READ_INPUTS,
            mrb_pkg::FC_READ_HOLDING, mrb_pkg::FC_READ_INPUT_REG: begin
              next_r.rd_cmd = 1'b1;
              next_r.state = mrb_pkg::MRB_WAIT_HOST;
            end
            mrb_pkg::FC_WRITE_COIL, mrb_pkg::FC_WRITE_REG,
            mrb_pkg::FC_WRITE_COILS, mrb_pkg::FC_WRITE_REGS: begin
              next_r.wr_cmd = 1'b1;
              next_r.state = mrb_pkg::MRB_WAIT_HOST;
            end
            default: begin
              // loopback and all others: exception reply, no echo
              next_r.frame[1] = r.frame[1] | mrb_pkg::EXC_FLAG;
              next_r.frame[2] = mrb_pkg::EXC_ILLEGAL_FC;
              next_r.tx_len = mrb_pkg::EXC_LEN;
              next_r.tx_idx = '0;
              next_r.state = mrb_pkg::MRB_TX_DATA;
            end
          endcase
        end
      end
      mrb_pkg::MRB_WAIT_HOST: begin
        // only a pending request lets software start a reply
        if (acc && avs_write && ofs == mrb_pkg::OFS_TX_LEN
            && avs_writedata[6:0] != '0) begin
          next_r.tx_len = (avs_writedata[6:0] > 7'(mrb_pkg::BUF_DEPTH))
                          ? 7'(mrb_pkg::BUF_DEPTH) : avs_writedata[6:0];
          next_r.tx_idx = '0;
          next_r.state = mrb_pkg::MRB_TX_DATA;
        end
      end
      mrb_pkg::MRB_TX_DATA: begin
        if (!r.tx_valid && ch.tx_ready) begin
          next_r.tx_valid = 1'b1;
          next_r.tx_data = r.frame[r.tx_idx[5:0]];
          next_r.crc = crc_step(r.crc, r.frame[r.tx_idx[5:0]]);
          next_r.tx_idx = r.tx_idx + 1'b1;
          if (r.tx_idx + 1'b1 == r.tx_len) begin
            next_r.state = mrb_pkg::MRB_TX_CRC_LO;
          end
        end
      end
      mrb_pkg::MRB_TX_CRC_LO: begin
        if (!r.tx_valid && ch.tx_ready) begin
          next_r.tx_valid = 1'b1;
          next_r.tx_data = r.crc[7:0];
          next_r.state = mrb_pkg::MRB_TX_CRC_HI;
        end
      end
      mrb_pkg::MRB_TX_CRC_HI: begin
        if (!r.tx_valid && ch.tx_ready) begin
          next_r.tx_valid = 1'b1;
          next_r.tx_data = r.crc[15:8];
          next_r.crc = mrb_pkg::CRC_INIT;
          next_r.state = mrb_pkg::MRB_IDLE;
        end
      end
      default: begin
        next_r.state = mrb_pkg::MRB_IDLE;
      end
    endcase
    // bus slave: one wait cycle, then a single ready cycle
    if ((avs_read || avs_write) && r.waitreq) begin
      next_r.waitreq = 1'b0;
      next_r.rdata = '0;
      if (ofs == mrb_pkg::OFS_CTRL) begin
        next_r.rdata[mrb_pkg::CTRL_EN] = r.enable;
        next_r.rdata[mrb_pkg::CTRL_RATE_LSB +: 3] = r.rate_sel;
        next_r.rdata[mrb_pkg::CTRL_PAR_EN] = r.parity_enable;
        next_r.rdata[mrb_pkg::CTRL_PAR_EVEN] = r.parity_even_select;
        next_r.rdata[mrb_pkg::CTRL_STN_LSB +: 5] = r.station;
      end else if (ofs == mrb_pkg::OFS_STATUS) begin
        next_r.rdata[mrb_pkg::STAT_PENDING] = (r.state == mrb_pkg::MRB_WAIT_HOST);
        next_r.rdata[mrb_pkg::STAT_TX] = ch.tx_active;
        next_r.rdata[mrb_pkg::STAT_LEN_LSB +: 7] = r.rx_len;
      end else if (ofs == mrb_pkg::OFS_TX_LEN) begin
        next_r.rdata[6:0] = r.tx_len;
      end else if (ofs == mrb_pkg::OFS_DROPS) begin
        next_r.rdata[15:0] = r.drops;
      end else if (ofs >= mrb_pkg::OFS_BUF) begin
        next_r.rdata[7:0] = r.frame[buf_idx];
      end
    end
    if (acc && avs_write) begin
      if (ofs == mrb_pkg::OFS_CTRL) begin
        next_r.enable = avs_writedata[mrb_pkg::CTRL_EN];
        next_r.parity_enable = avs_writedata[mrb_pkg::CTRL_PAR_EN];
        next_r.parity_even_select = avs_writedata[mrb_pkg::CTRL_PAR_EVEN];
        if (avs_writedata[mrb_pkg::CTRL_RATE_LSB +: 3] != mrb_pkg::RATE_RESERVED) begin
          next_r.rate_sel = avs_writedata[mrb_pkg::CTRL_RATE_LSB +: 3];
        end
        // station zero is refused, the field cannot reach 32
        if (avs_writedata[mrb_pkg::CTRL_STN_LSB +: 5] != '0) begin
          next_r.station = avs_writedata[mrb_pkg::CTRL_STN_LSB +: 5];
        end
      end else if (ofs >= mrb_pkg::OFS_BUF && r.state == mrb_pkg::MRB_WAIT_HOST) begin
        next_r.frame[buf_idx] = avs_writedata[7:0]; // reply is staged in place
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      r <= '0;
      r.state <= mrb_pkg::MRB_IDLE;
      r.waitreq <= 1'b1;
      r.enable <= mrb_pkg::RST_EN;
      r.rate_sel <= mrb_pkg::RST_RATE;
      r.station <= mrb_pkg::RST_STATION;
      r.crc <= mrb_pkg::CRC_INIT;
    end else begin
      r <= next_r;
    end
  end
endmodule

//--- tb/mrb_bridge_properties.sv
// checker: bus handshake, command pulse and line assertions of the bridge
module mrb_bridge_properties #(
  parameter int CLK_HZ = 20_000_000
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic line_tx,
  input wire logic line_tx_oe,
  input wire logic internal_read_command,
  input wire logic internal_write_command,
  input wire logic [7:0] cmd_function
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // bus access steps: request waiting, then one low cycle of waitrequest
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_bus_one_wait: assert property (s_req |=> s_ack)
    else $error("waitrequest not low for exactly one cycle");
  a_ack_has_req: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("waitrequest low without a request");
  a_read_codes: assert property (
    internal_read_command |-> cmd_function inside {[8'h01:8'h04]})
    else $error("read command for a wrong function code");
  a_write_codes: assert property (
    internal_write_command |-> cmd_function inside {8'h05, 8'h06, 8'h0F, 8'h10})
    else $error("write command for a wrong function code");
  a_cmd_single: assert property (
    (internal_read_command || internal_write_command)
      |=> !internal_read_command && !internal_write_command)
    else $error("command pulse longer than one cycle");
  a_idle_high: assert property (!line_tx_oe |-> line_tx)
    else $error("line not idle high while released");
  a_start_bit: assert property ($rose(line_tx_oe) |-> !line_tx)
    else $error("character does not open with a start bit");
  a_oe_hold: assert property ($rose(line_tx_oe) |-> line_tx_oe [*4])
    else $error("driver released inside the start bit");
  a_quiet_in_tx: assert property (
    line_tx_oe |-> !internal_read_command && !internal_write_command)
    else $error("request accepted while transmitting");
endmodule

bind mrb_bridge mrb_bridge_properties #(.CLK_HZ(CLK_HZ)) u_props (
  .sys_clk(sys_clk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .line_tx(line_tx), .line_tx_oe(line_tx_oe),
  .internal_read_command(internal_read_command),
  .internal_write_command(internal_write_command), .cmd_function(cmd_function));

//--- tb/mrb_master_model.sv
// partner: serial master on the shared line, sends requests and collects replies
module mrb_master_model (
  input wire logic sys_clk,
  input wire logic line_tx,
  input wire logic line_tx_oe,
  output logic line_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  int bit_cyc = 20;
  int n_bad = 0;
  logic par_en = 1'b0;
  logic par_even = 1'b0;
  logic m_tx = 1'b1;
  logic busy = 1'b0;
  logic [7:0] rx_q[$];
  // responder wins while enabled; otherwise the master level, biased high when idle
  assign line_rx = line_tx_oe ? line_tx : m_tx;
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  task automatic bit_out(input logic b);
    m_tx <= b;
    repeat (bit_cyc) @(posedge sys_clk);
  endtask
  // whole frame with crc low byte first; faults only when the bench asks
  task automatic send_frame(input logic [7:0] q[$], input logic bad_crc, input logic bad_par);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad_crc};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    busy = 1'b1;
    @(posedge sys_clk);
    foreach (q[i]) begin
      bit_out(1'b0);
      for (int k = 0; k < 8; k++) bit_out(q[i][k]);
      if (par_en) bit_out(^q[i] ^ !par_even ^ bad_par);
      bit_out(1'b1);
    end
    busy = 1'b0;
  endtask
  // collect replies mid-bit; parity and stop errors are counted
  initial forever begin
    logic [7:0] d;
    @(posedge sys_clk);
    if (line_tx_oe && !line_tx) begin
      repeat (bit_cyc / 2) @(posedge sys_clk);
      for (int k = 0; k < 8; k++) begin
        repeat (bit_cyc) @(posedge sys_clk);
        d[k] = line_tx;
      end
      if (par_en) begin
        repeat (bit_cyc) @(posedge sys_clk);
        if (line_tx !== (^d ^ !par_even)) n_bad++;
      end
      repeat (bit_cyc) @(posedge sys_clk);
      if (line_tx !== 1'b1) n_bad++;
      rx_q.push_back(d);
    end
  end
  // the master never talks over a responder
  always @(posedge sys_clk) if (busy && line_tx_oe) n_bad++;
endmodule

//--- tb/mrb_bridge_tb.sv
// testbench: register access and serial exchanges with the bridge
module mrb_bridge_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CLK_HZ = 200_000; // short bit times keep the run small
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [6:0] avs_address = 7'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, line_rx, line_tx, line_tx_oe, rd_cmd, wr_cmd;
  logic [7:0] cmd_function;
  logic [15:0] cmd_start, cmd_quantity;
  logic [7:0] req[$];
  logic [7:0] exp_q[$];
  int bauds[8] = '{0, 300, 600, 1200, 2400, 4800, 9600, 19200};
  logic [7:0] fcs[9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0F, 8'h10, 8'h08};
  int kinds[9] = '{1, 1, 1, 1, 2, 2, 2, 2, 3};
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int got_rd = 0;
  int got_wr = 0;
  `define MRB_CHECK(act, exp, msg) \
    begin checks++; if ((act) !== (exp)) begin n_mismatch++; \
    $display("mismatch at %0t: %s", $time, msg); end end
  always #25 sys_clk = ~sys_clk;
  mrb_bridge #(.CLK_HZ(CLK_HZ)) u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .line_rx(line_rx), .line_tx(line_tx),
    .line_tx_oe(line_tx_oe), .internal_read_command(rd_cmd),
    .internal_write_command(wr_cmd), .cmd_function(cmd_function),
    .cmd_start(cmd_start), .cmd_quantity(cmd_quantity));
  mrb_master_model u_mst (
    .sys_clk(sys_clk), .line_tx(line_tx), .line_tx_oe(line_tx_oe), .line_rx(line_rx));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // pulse counters and the hang limit; a pulse stands one cycle so is seen once
  always @(posedge sys_clk) begin
    cyc++;
    if (rd_cmd === 1'b1) got_rd++;
    if (wr_cmd === 1'b1) got_wr++;
    if (cyc > 60000) begin
      n_mismatch++;
      finish_test();
    end
  end
  // one avalon access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0); // only the hang limit ends a wait
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic cfg(input logic [4:0] stn, input logic [2:0] rate, input logic pe, input logic pv);
    bus(1'b1, 7'h00, {21'h000000, stn, pv, pe, rate, 1'b1});
    u_mst.bit_cyc = CLK_HZ / bauds[rate];
    u_mst.par_en = pe;
    u_mst.par_even = pv;
  endtask
  // kind: 0 silent, 1 read command, 2 write command, 3 exception reply
  task automatic xchg(input logic [7:0] stn, input logic [7:0] fc, input int kind,
                      input logic bc, input logic bp);
    logic [15:0] c;
    req = '{stn, fc, 8'h01, fc, 8'h00, 8'h02};
    exp_q.delete();
    u_mst.rx_q.delete();
    got_rd = 0;
    got_wr = 0;
    u_mst.send_frame(req, bc, bp);
    repeat (u_mst.bit_cyc * 45) @(posedge sys_clk);
    `MRB_CHECK(got_rd, int'(kind == 1), "read command count")
    `MRB_CHECK(got_wr, int'(kind == 2), "write command count")
    if (kind == 1 || kind == 2) begin
      `MRB_CHECK(cmd_function, fc, "command function")
      `MRB_CHECK(cmd_start, {8'h01, fc}, "command start")
      `MRB_CHECK(cmd_quantity, 16'h0002, "command quantity")
      bus(1'b0, 7'h01, 32'h0);
      `MRB_CHECK(rd[0], 1'b1, "request pending")
      bus(1'b1, 7'h40, {24'h0, stn});
      bus(1'b1, 7'h41, {24'h0, fc});
      bus(1'b1, 7'h42, 32'h0000005A); // differs from the request byte
      bus(1'b1, 7'h02, 32'h00000003);
      exp_q = '{stn, fc, 8'h5A};
    end
    if (kind == 3) exp_q = '{stn, fc | 8'h80, 8'h01};
    if (kind != 0) begin
      c = u_mst.crc16(exp_q);
      exp_q.push_back(c[7:0]);
      exp_q.push_back(c[15:8]);
    end
    repeat (u_mst.bit_cyc * 60) @(posedge sys_clk);
    `MRB_CHECK(u_mst.rx_q.size(), exp_q.size(), "reply length")
    foreach (exp_q[i]) `MRB_CHECK(u_mst.rx_q[i], exp_q[i], "reply byte")
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    bus(1'b0, 7'h00, 32'h0);
    `MRB_CHECK(rd, 32'h0000004D, "control reset value")
    bus(1'b0, 7'h05, 32'h0);
    `MRB_CHECK(rd, 32'h00000000, "unmapped read")
    bus(1'b1, 7'h00, 32'h00000141);
    bus(1'b0, 7'h00, 32'h0);
    `MRB_CHECK(rd, 32'h0000014D, "reserved rate kept old")
    bus(1'b1, 7'h00, 32'h0000000F);
    bus(1'b0, 7'h00, 32'h0);
    `MRB_CHECK(rd, 32'h0000014F, "station zero kept old")
    $display("test registers done");
    // the eight handled function codes and loopback, under alternating rates and a cycle of no, odd and even parity
    for (int i = 0; i < 9; i++) begin
      cfg(5'h05, i[0] ? 3'h7 : 3'h6, i % 3 != 0, i % 3 == 2);
      xchg(8'h05, fcs[i], kinds[i], 1'b0, 1'b0);
    end
    $display("test function codes done");
    xchg(8'h06, 8'h03, 0, 1'b0, 1'b0);
    xchg(8'h00, 8'h03, 0, 1'b0, 1'b0);
    xchg(8'h05, 8'h03, 0, 1'b1, 1'b0);
    xchg(8'h05, 8'h03, 0, 1'b0, 1'b1);
    bus(1'b0, 7'h03, 32'h0);
    `MRB_CHECK(rd, 32'h00000002, "dropped frame count")
    `MRB_CHECK(u_mst.n_bad, 0, "line framing or collision")
    $display("test foreign and bad frames done");
    // reset in mid-run brings back the defaults and clears the drop count
    rstn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    bus(1'b0, 7'h00, 32'h0);
    `MRB_CHECK(rd, 32'h0000004D, "control after reset")
    bus(1'b0, 7'h03, 32'h0);
    `MRB_CHECK(rd, 32'h00000000, "drops after reset")
    $display("test mid-run reset done");
    finish_test();
  end
endmodule
